// File: rtl/asjd_decoder.sv
// Top of the decoder: takes bytes from the prefetch queue and issues controls.
`timescale 1ns/1ps
module asjd_decoder
  import asjd_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            sys_rst,
  input  wire logic [7:0]      q_byte,
  input  wire logic            q_valid,
  output logic                 q_ready,
  output logic                 dec_valid,
  input  wire logic            dec_ready,
  output asjd_pkg::asjd_op_t   dec_op,
  output asjd_pkg::asjd_form_t dec_form,
  output logic                 dec_word,
  output logic                 dec_reg_dest,
  output logic                 dec_count_reg,
  output logic [1:0]           dec_mod,
  output logic [2:0]           dec_reg,
  output logic [2:0]           dec_rm,
  output logic [1:0]           dec_imm_bytes,
  output logic                 dec_flags_only,
  output logic                 dec_repeat,
  output logic                 dec_repeat_z,
  output logic                 dec_illegal
);

  import asjd_pkg::*;

  typedef enum logic [1:0] {ASJD_ST_FIRST, ASJD_ST_SECOND, ASJD_ST_HOLD} asjd_state_t;

  asjd_state_t state_r;
  logic [7:0]  opcode_r;
  logic        rep_r;
  logic        rep_z_r;
  logic        need_modrm;
  logic        known;
  asjd_op_t   op_c;
  asjd_form_t form_c;
  logic [1:0]  imm_c;
  logic        ill_c;
  logic [7:0]  dec_opcode;
  logic [7:0]  dec_modrm;
  logic        is_rep;
  logic        take_first;
  logic        take_second;
  logic        finish;

  asjd_first_class u_class (
    .opcode     (q_byte),
    .need_modrm (need_modrm),
    .known      (known)
  );

  // Single-byte opcodes decode straight from the queue byte; two-byte ones from the latch.
  assign dec_opcode = (state_r == ASJD_ST_SECOND) ? opcode_r : q_byte;
  assign dec_modrm  = (state_r == ASJD_ST_SECOND) ? q_byte : 8'h00;

  asjd_op_decode u_dec (
    .opcode    (dec_opcode),
    .modrm     (dec_modrm),
    .op        (op_c),
    .form      (form_c),
    .imm_bytes (imm_c),
    .illegal   (ill_c)
  );

  assign is_rep      = asjd_match(q_byte, ASJD_RPT, ASJD_MASK1);
  assign q_ready     = (state_r != ASJD_ST_HOLD);
  assign take_first  = (state_r == ASJD_ST_FIRST) && q_valid;
  assign take_second = (state_r == ASJD_ST_SECOND) && q_valid;
  assign finish      = (take_first && !is_rep && !need_modrm) || take_second;
  assign dec_valid   = (state_r == ASJD_ST_HOLD);

  // Sequencing: first byte, optional second byte, then hold until the execution unit takes it.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      state_r <= ASJD_ST_FIRST;
    else
      unique case (state_r)
        ASJD_ST_FIRST:
          if (take_first && !is_rep)
            state_r <= need_modrm ? ASJD_ST_SECOND : ASJD_ST_HOLD;
        ASJD_ST_SECOND:
          if (take_second)
            state_r <= ASJD_ST_HOLD;
        ASJD_ST_HOLD:
          if (dec_ready)
            state_r <= ASJD_ST_FIRST;
      endcase
  end

  // Latch the opcode while waiting for its second byte.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      opcode_r <= 8'h00;
    else if (take_first)
      opcode_r <= q_byte;
  end

  // Repeat prefix is remembered with its condition bit and cleared on issue.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rep_r   <= 1'b0;
      rep_z_r <= 1'b0;
    end
    else if (take_first && is_rep)
    begin
      rep_r   <= 1'b1;
      rep_z_r <= q_byte[ASJD_W_BIT];
    end
    else if (dec_valid && dec_ready)
    begin
      rep_r   <= 1'b0;
      rep_z_r <= 1'b0;
    end
  end

  // Registered control outputs, loaded when the instruction completes.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      dec_op         <= ASJD_OP_NONE;
      dec_form       <= ASJD_FORM_NONE;
      dec_word       <= 1'b0;
      dec_reg_dest   <= 1'b0;
      dec_count_reg  <= 1'b0;
      dec_mod        <= 2'd0;
      dec_reg        <= 3'd0;
      dec_rm         <= 3'd0;
      dec_imm_bytes  <= 2'd0;
      dec_flags_only <= 1'b0;
      dec_illegal    <= 1'b0;
    end
    else if (finish)
    begin
      dec_op        <= op_c;
      dec_form      <= form_c;
      dec_imm_bytes <= imm_c;
      dec_illegal   <= ill_c || (take_first && !known);
      // Word bit is absent in fixed opcodes; those set it from their own width.
      if (dec_opcode == ASJD_XWD)
        dec_word <= 1'b1;
      else if (dec_opcode == ASJD_XBW || op_c == ASJD_OP_JUMP)
        dec_word <= 1'b1;
      else if (op_c inside {ASJD_OP_AAJ, ASJD_OP_DAJ, ASJD_OP_ASJ, ASJD_OP_DSJ,
                            ASJD_OP_AMJ, ASJD_OP_ADJ})
        dec_word <= 1'b0;
      else
        dec_word <= dec_opcode[ASJD_W_BIT];
      dec_reg_dest  <= (form_c == ASJD_FORM_RM_REG) && dec_opcode[ASJD_D_BIT];
      dec_count_reg <= (op_c inside {ASJD_OP_ROTL, ASJD_OP_ROTR, ASJD_OP_RLC_C,
                                     ASJD_OP_RRC_C, ASJD_OP_SHLEFT, ASJD_OP_SHRL,
                                     ASJD_OP_SHRA}) && dec_opcode[ASJD_V_BIT];
      dec_mod        <= dec_modrm[ASJD_MOD_HI:ASJD_MOD_LO];
      dec_reg        <= dec_modrm[ASJD_REG_HI:ASJD_REG_LO];
      dec_rm         <= dec_modrm[ASJD_RM_HI:ASJD_RM_LO];
      dec_flags_only <= (op_c == ASJD_OP_TEST);
    end
  end

  // Repeat qualifiers shown with the instruction they prefix.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      dec_repeat   <= 1'b0;
      dec_repeat_z <= 1'b0;
    end
    else if (finish)
    begin
      dec_repeat   <= rep_r;
      dec_repeat_z <= rep_z_r;
    end
  end

endmodule

// File: rtl/asjd_first_class.sv
// First-byte classifier: tells whether an opcode needs a second byte.
`timescale 1ns/1ps
module asjd_first_class
  import asjd_pkg::*;
(
  input  wire logic [7:0] opcode,
  output logic            need_modrm,
  output logic            known
);

  // Opcodes that take a second byte: an operand selector or address, or the base-ten constant.
  always_comb
  begin
    need_modrm = asjd_match(opcode, ASJD_ADC_RR, ASJD_MASK2) |
                 asjd_match(opcode, ASJD_SWB_RR, ASJD_MASK2) |
                 asjd_match(opcode, ASJD_SUB_RR, ASJD_MASK2) |
                 asjd_match(opcode, ASJD_IMM_GRP, ASJD_MASK2) |
                 asjd_match(opcode, ASJD_UNARY, ASJD_MASK1) |
                 asjd_match(opcode, ASJD_SHIFT, ASJD_MASK2) |
                 (opcode == ASJD_GRP_FF) | (opcode == ASJD_AMJ) | (opcode == ASJD_ADJ);
    known = need_modrm |
            asjd_match(opcode, ASJD_ADC_ACC, ASJD_MASK1) |
            asjd_match(opcode, ASJD_SWB_ACC, ASJD_MASK1) |
            asjd_match(opcode, ASJD_SUB_ACC, ASJD_MASK1) |
            asjd_match(opcode, ASJD_AND_ACC, ASJD_MASK1) |
            asjd_match(opcode, ASJD_TEST_ACC, ASJD_MASK1) |
            asjd_match(opcode, ASJD_SMOVE, ASJD_MASK1) |
            asjd_match(opcode, ASJD_SCMP, ASJD_MASK1) |
            asjd_match(opcode, ASJD_SSCAN, ASJD_MASK1) |
            asjd_match(opcode, ASJD_SLOAD, ASJD_MASK1) |
            asjd_match(opcode, ASJD_SSTORE, ASJD_MASK1) |
            asjd_match(opcode, ASJD_RPT, ASJD_MASK1) |
            (opcode == ASJD_AAJ) | (opcode == ASJD_DAJ) | (opcode == ASJD_ASJ) |
            (opcode == ASJD_DSJ) | (opcode == ASJD_XBW) | (opcode == ASJD_XWD) |
            (opcode == ASJD_JP_NEAR) | (opcode == ASJD_JP_SHRT);
  end

endmodule

// File: rtl/asjd_op_decode.sv
// Combinational decode of an opcode and its second byte into an operation.
`timescale 1ns/1ps
module asjd_op_decode
  import asjd_pkg::*;
(
  input  wire logic [7:0]      opcode,
  input  wire logic [7:0]      modrm,
  output asjd_pkg::asjd_op_t   op,
  output asjd_pkg::asjd_form_t form,
  output logic [1:0]           imm_bytes,
  output logic                 illegal
);

  logic [2:0] sel;
  logic       w;

  assign sel = modrm[ASJD_REG_HI:ASJD_REG_LO];
  assign w   = opcode[ASJD_W_BIT];

  // Priority-free decode; the opcode groups do not overlap.
  always_comb
  begin
    op        = ASJD_OP_NONE;
    form      = ASJD_FORM_NONE;
    imm_bytes = 2'd0;
    illegal   = 1'b0;
    if (asjd_match(opcode, ASJD_ADC_RR, ASJD_MASK2))
    begin
      op   = ASJD_OP_ADC;
      form = ASJD_FORM_RM_REG;
    end
    else if (asjd_match(opcode, ASJD_SUB_RR, ASJD_MASK2))
    begin
      op   = ASJD_OP_SUB;
      form = ASJD_FORM_RM_REG;
    end
    else if (asjd_match(opcode, ASJD_SWB_RR, ASJD_MASK2))
    begin
      op   = ASJD_OP_SWB;
      form = ASJD_FORM_RM_REG;
    end
    else if (asjd_match(opcode, ASJD_IMM_GRP, ASJD_MASK2))
    begin
      form = ASJD_FORM_RM_IMM;
      // Sign-extended forms carry one data byte; plain word forms carry two.
      imm_bytes = (w && !opcode[ASJD_S_BIT]) ? 2'd2 : 2'd1;
      unique case (sel)
        ASJD_SEL_010: op = ASJD_OP_ADC;
        ASJD_SEL_101: op = ASJD_OP_SUB;
        ASJD_SEL_011: op = ASJD_OP_SWB;
        ASJD_SEL_100: op = ASJD_OP_AND;
        default:
        begin
          // Add, compare, or and xor are handled elsewhere in the core.
          op        = ASJD_OP_NONE;
          form      = ASJD_FORM_NONE;
          imm_bytes = 2'd0;
        end
      endcase
    end
    else if (asjd_match(opcode, ASJD_ADC_ACC, ASJD_MASK1) ||
             asjd_match(opcode, ASJD_SUB_ACC, ASJD_MASK1) ||
             asjd_match(opcode, ASJD_SWB_ACC, ASJD_MASK1) ||
             asjd_match(opcode, ASJD_AND_ACC, ASJD_MASK1) ||
             asjd_match(opcode, ASJD_TEST_ACC, ASJD_MASK1))
    begin
      form      = ASJD_FORM_ACC_IMM;
      imm_bytes = w ? 2'd2 : 2'd1;
      if (asjd_match(opcode, ASJD_ADC_ACC, ASJD_MASK1))
        op = ASJD_OP_ADC;
      else if (asjd_match(opcode, ASJD_SUB_ACC, ASJD_MASK1))
        op = ASJD_OP_SUB;
      else if (asjd_match(opcode, ASJD_SWB_ACC, ASJD_MASK1))
        op = ASJD_OP_SWB;
      else if (asjd_match(opcode, ASJD_AND_ACC, ASJD_MASK1))
        op = ASJD_OP_AND;
      else
        op = ASJD_OP_TEST;
    end
    else if (asjd_match(opcode, ASJD_UNARY, ASJD_MASK1))
    begin
      form = ASJD_FORM_RM;
      unique case (sel)
        ASJD_SEL_000:
        begin
          op        = ASJD_OP_TEST;
          form      = ASJD_FORM_RM_IMM;
          imm_bytes = w ? 2'd2 : 2'd1;
        end
        ASJD_SEL_010: op = ASJD_OP_NOT;
        ASJD_SEL_011: op = ASJD_OP_CHS;
        ASJD_SEL_100: op = ASJD_OP_MLU;
        ASJD_SEL_101: op = ASJD_OP_MULS;
        ASJD_SEL_110: op = ASJD_OP_DIV;
        ASJD_SEL_111: op = ASJD_OP_DIVS;
        default:
        begin
          op      = ASJD_OP_NONE;
          form    = ASJD_FORM_NONE;
          illegal = 1'b1;
        end
      endcase
    end
    else if (asjd_match(opcode, ASJD_SHIFT, ASJD_MASK2))
    begin
      form = ASJD_FORM_RM;
      unique case (sel)
        ASJD_SEL_000: op = ASJD_OP_ROTL;
        ASJD_SEL_001: op = ASJD_OP_ROTR;
        ASJD_SEL_010: op = ASJD_OP_RLC_C;
        ASJD_SEL_011: op = ASJD_OP_RRC_C;
        ASJD_SEL_100: op = ASJD_OP_SHLEFT;
        ASJD_SEL_101: op = ASJD_OP_SHRL;
        ASJD_SEL_111: op = ASJD_OP_SHRA;
        default:
        begin
          op      = ASJD_OP_NONE;
          form    = ASJD_FORM_NONE;
          illegal = 1'b1;
        end
      endcase
    end
    else if (opcode == ASJD_AMJ || opcode == ASJD_ADJ)
    begin
      form = ASJD_FORM_ACC;
      // The second byte must be the base-ten constant.
      if (modrm == ASJD_BASE_TEN)
        op = (opcode == ASJD_AMJ) ? ASJD_OP_AMJ : ASJD_OP_ADJ;
      else
      begin
        form    = ASJD_FORM_NONE;
        illegal = 1'b1;
      end
    end
    else if (opcode == ASJD_GRP_FF)
    begin
      if (sel == ASJD_SEL_100)
      begin
        op   = ASJD_OP_JUMP;
        form = ASJD_FORM_RM;
      end
    end
    else
    begin
      form = ASJD_FORM_ACC;
      if (opcode == ASJD_AAJ)
        op = ASJD_OP_AAJ;
      else if (opcode == ASJD_DAJ)
        op = ASJD_OP_DAJ;
      else if (opcode == ASJD_ASJ)
        op = ASJD_OP_ASJ;
      else if (opcode == ASJD_DSJ)
        op = ASJD_OP_DSJ;
      else if (opcode == ASJD_XBW)
        op = ASJD_OP_XBW_EXT;
      else if (opcode == ASJD_XWD)
        op = ASJD_OP_XWD_EXT;
      else if (asjd_match(opcode, ASJD_SMOVE, ASJD_MASK1))
        op = ASJD_OP_SMOVE;
      else if (asjd_match(opcode, ASJD_SCMP, ASJD_MASK1))
        op = ASJD_OP_SCMP;
      else if (asjd_match(opcode, ASJD_SSCAN, ASJD_MASK1))
        op = ASJD_OP_SSCAN;
      else if (asjd_match(opcode, ASJD_SLOAD, ASJD_MASK1))
        op = ASJD_OP_SLOAD;
      else if (asjd_match(opcode, ASJD_SSTORE, ASJD_MASK1))
        op = ASJD_OP_SSTORE;
      else if (opcode == ASJD_JP_NEAR || opcode == ASJD_JP_SHRT)
      begin
        op        = ASJD_OP_JUMP;
        form      = ASJD_FORM_DISP;
        imm_bytes = (opcode == ASJD_JP_NEAR) ? 2'd2 : 2'd1;
      end
      else
        form = ASJD_FORM_NONE;
    end
  end

endmodule

// File: rtl/asjd_pkg.sv
// Constants, opcode patterns and operation codes for the arithmetic, string and jump decoder.
package asjd_pkg;

  // Operation codes handed to the execution unit.
  typedef enum logic [5:0] {
    ASJD_OP_NONE, ASJD_OP_ADC, ASJD_OP_SUB, ASJD_OP_SWB, ASJD_OP_AND, ASJD_OP_TEST,
    ASJD_OP_NOT, ASJD_OP_CHS, ASJD_OP_MLU, ASJD_OP_MULS, ASJD_OP_DIV, ASJD_OP_DIVS,
    ASJD_OP_AAJ, ASJD_OP_DAJ, ASJD_OP_ASJ, ASJD_OP_DSJ, ASJD_OP_AMJ, ASJD_OP_ADJ,
    ASJD_OP_XBW_EXT, ASJD_OP_XWD_EXT, ASJD_OP_ROTL, ASJD_OP_ROTR, ASJD_OP_RLC_C,
    ASJD_OP_RRC_C, ASJD_OP_SHLEFT, ASJD_OP_SHRL, ASJD_OP_SHRA, ASJD_OP_SMOVE,
    ASJD_OP_SCMP, ASJD_OP_SSCAN, ASJD_OP_SLOAD, ASJD_OP_SSTORE, ASJD_OP_JUMP
  } asjd_op_t;

  // Operand selection forms.
  typedef enum logic [2:0] {
    ASJD_FORM_NONE, ASJD_FORM_RM_REG, ASJD_FORM_RM_IMM, ASJD_FORM_ACC_IMM,
    ASJD_FORM_RM, ASJD_FORM_ACC, ASJD_FORM_DISP
  } asjd_form_t;

  // First-byte opcode patterns; the low one or two bits are masked where noted.
  localparam logic [7:0] ASJD_ADC_RR   = 8'h10; // Low two bits d and w.
  localparam logic [7:0] ASJD_SWB_RR   = 8'h18;
  localparam logic [7:0] ASJD_SUB_RR   = 8'h28;
  localparam logic [7:0] ASJD_ADC_ACC  = 8'h14; // Low bit w.
  localparam logic [7:0] ASJD_SWB_ACC  = 8'h1c;
  localparam logic [7:0] ASJD_AND_ACC  = 8'h24;
  localparam logic [7:0] ASJD_SUB_ACC  = 8'h2c;
  localparam logic [7:0] ASJD_TEST_ACC = 8'ha8;
  localparam logic [7:0] ASJD_IMM_GRP  = 8'h80; // Low two bits s and w.
  localparam logic [7:0] ASJD_UNARY    = 8'hf6; // Low bit w.
  localparam logic [7:0] ASJD_SHIFT    = 8'hd0; // Low two bits v and w.
  localparam logic [7:0] ASJD_SMOVE    = 8'ha4;
  localparam logic [7:0] ASJD_SCMP     = 8'ha6;
  localparam logic [7:0] ASJD_SSTORE   = 8'haa;
  localparam logic [7:0] ASJD_SLOAD    = 8'hac;
  localparam logic [7:0] ASJD_SSCAN    = 8'hae;
  localparam logic [7:0] ASJD_RPT      = 8'hf2; // Low bit z.
  localparam logic [7:0] ASJD_AAJ      = 8'h37;
  localparam logic [7:0] ASJD_DAJ      = 8'h27;
  localparam logic [7:0] ASJD_ASJ      = 8'h3f;
  localparam logic [7:0] ASJD_DSJ      = 8'h2f;
  localparam logic [7:0] ASJD_AMJ      = 8'hd4;
  localparam logic [7:0] ASJD_ADJ      = 8'hd5;
  localparam logic [7:0] ASJD_BASE_TEN = 8'h0a;
  localparam logic [7:0] ASJD_XBW      = 8'h98;
  localparam logic [7:0] ASJD_XWD      = 8'h99;
  localparam logic [7:0] ASJD_JP_NEAR  = 8'he9;
  localparam logic [7:0] ASJD_JP_SHRT  = 8'heb;
  localparam logic [7:0] ASJD_GRP_FF   = 8'hff;

  // Masks that drop the low one or two variable bits.
  localparam logic [7:0] ASJD_MASK1 = 8'hfe;
  localparam logic [7:0] ASJD_MASK2 = 8'hfc;

  // Second-byte selectors.
  localparam logic [2:0] ASJD_SEL_000 = 3'h0;
  localparam logic [2:0] ASJD_SEL_001 = 3'h1;
  localparam logic [2:0] ASJD_SEL_010 = 3'h2;
  localparam logic [2:0] ASJD_SEL_011 = 3'h3;
  localparam logic [2:0] ASJD_SEL_100 = 3'h4;
  localparam logic [2:0] ASJD_SEL_101 = 3'h5;
  localparam logic [2:0] ASJD_SEL_110 = 3'h6;
  localparam logic [2:0] ASJD_SEL_111 = 3'h7;

  // Field positions of the second byte.
  localparam int ASJD_MOD_HI = 7;
  localparam int ASJD_MOD_LO = 6;
  localparam int ASJD_REG_HI = 5;
  localparam int ASJD_REG_LO = 3;
  localparam int ASJD_RM_HI  = 2;
  localparam int ASJD_RM_LO  = 0;

  // Opcode bit positions.
  localparam int ASJD_W_BIT = 0;
  localparam int ASJD_D_BIT = 1;
  localparam int ASJD_V_BIT = 1;
  localparam int ASJD_S_BIT = 1;

  // Match an opcode against a pattern under a mask.
  function automatic logic asjd_match(input logic [7:0] op, input logic [7:0] pat,
                                      input logic [7:0] mask);
    asjd_match = ((op & mask) == pat);
  endfunction

endpackage

// File: sim/asjd_decoder_asserts.sv
// Concurrent checks on the decoder top ports, bound to every instance of the top.
`timescale 1ns/1ps
module asjd_decoder_chk
  import asjd_pkg::*;
(
  input logic                 ref_clk,
  input logic                 sys_rst,
  input logic [7:0]           q_byte,
  input logic                 q_valid,
  input logic                 q_ready,
  input logic                 dec_valid,
  input asjd_pkg::asjd_op_t   dec_op,
  input asjd_pkg::asjd_form_t dec_form,
  input logic                 dec_word,
  input logic                 dec_reg_dest,
  input logic                 dec_count_reg,
  input logic [1:0]           dec_imm_bytes
);
  logic take;
  logic lsb;
  logic dbit;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Byte taken this edge and its two low opcode bits.
  assign take = q_valid && q_ready;
  assign lsb  = q_byte[0];
  assign dbit = q_byte[1];

  property p_adj_add;
    $rose(dec_valid) && dec_op inside {ASJD_OP_AAJ, ASJD_OP_DAJ}
      |-> $past(q_byte) == ((dec_op == ASJD_OP_AAJ) ? 8'h37 : 8'h27);
  endproperty
  a_adj_add: assert property (p_adj_add) else $error("add adjust from wrong opcode");
  property p_adj_sub;
    $rose(dec_valid) && dec_op inside {ASJD_OP_ASJ, ASJD_OP_DSJ}
      |-> $past(q_byte) == ((dec_op == ASJD_OP_ASJ) ? 8'h3f : 8'h2f);
  endproperty
  a_adj_sub: assert property (p_adj_sub) else $error("sub adjust from wrong opcode");
  property p_str_size;
    $rose(dec_valid) && dec_op inside {ASJD_OP_SMOVE, ASJD_OP_SCMP, ASJD_OP_SSCAN,
      ASJD_OP_SLOAD, ASJD_OP_SSTORE} |-> dec_word == $past(lsb);
  endproperty
  a_str_size: assert property (p_str_size) else $error("string size wrong");
  property p_count;
    $rose(dec_valid) && $past(take, 2) && dec_op inside {ASJD_OP_ROTL, ASJD_OP_ROTR,
      ASJD_OP_RLC_C, ASJD_OP_RRC_C, ASJD_OP_SHLEFT, ASJD_OP_SHRL, ASJD_OP_SHRA}
      |-> dec_count_reg == $past(dbit, 2);
  endproperty
  a_count: assert property (p_count) else $error("shift count source wrong");
  property p_word;
    $rose(dec_valid) && $past(take, 2) && !(dec_op inside {ASJD_OP_NONE, ASJD_OP_ADJ})
      && dec_form inside {ASJD_FORM_RM_REG, ASJD_FORM_RM_IMM, ASJD_FORM_RM}
      |-> dec_word == $past(lsb, 2);
  endproperty
  a_word: assert property (p_word) else $error("operand size wrong");
  property p_reg_dest;
    $rose(dec_valid) && $past(take, 2) && dec_form == ASJD_FORM_RM_REG
      |-> dec_reg_dest == $past(dbit, 2);
  endproperty
  a_reg_dest: assert property (p_reg_dest) else $error("destination wrong");
  property p_acc_imm;
    $rose(dec_valid) && dec_form == ASJD_FORM_ACC_IMM
      |-> dec_imm_bytes == ($past(lsb) ? 2'h2 : 2'h1);
  endproperty
  a_acc_imm: assert property (p_acc_imm) else $error("data byte count wrong");
  property p_jump;
    $rose(dec_valid) && dec_op == ASJD_OP_JUMP |-> dec_imm_bytes ==
      ($past(q_byte) == 8'he9 ? 2'h2 : ($past(q_byte) == 8'heb ? 2'h1 : 2'h0));
  endproperty
  a_jump: assert property (p_jump) else $error("jump displacement wrong");
endmodule

bind asjd_decoder asjd_decoder_chk i_asjd_decoder_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .q_byte(q_byte), .q_valid(q_valid),
  .q_ready(q_ready), .dec_valid(dec_valid), .dec_op(dec_op), .dec_form(dec_form),
  .dec_word(dec_word), .dec_reg_dest(dec_reg_dest), .dec_count_reg(dec_count_reg),
  .dec_imm_bytes(dec_imm_bytes)
);

// File: sim/asjd_decoder_bench.sv
// Self-checking bench for the decoder against the queue and execution-unit model.
`timescale 1ns/1ps
module asjd_decoder_bench;
  import asjd_pkg::*;
  localparam asjd_form_t F_NO = ASJD_FORM_NONE;
  localparam asjd_form_t F_RR = ASJD_FORM_RM_REG;
  localparam asjd_form_t F_RI = ASJD_FORM_RM_IMM;
  localparam asjd_form_t F_AI = ASJD_FORM_ACC_IMM;
  logic       ref_clk, sys_rst, q_valid, q_ready, dec_valid, dec_ready;
  logic [7:0] q_byte;
  asjd_op_t   dec_op;
  asjd_form_t dec_form;
  logic       dec_word, dec_reg_dest, dec_count_reg, dec_flags_only;
  logic       dec_repeat, dec_repeat_z, dec_illegal;
  logic [1:0] dec_mod, dec_imm_bytes;
  logic [2:0] dec_reg, dec_rm;
  logic [3:0] stall_cycles;
  int         err_total, check_count, cycles;

  asjd_decoder i_asjd_decoder (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .q_byte(q_byte), .q_valid(q_valid),
    .q_ready(q_ready), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_op(dec_op),
    .dec_form(dec_form), .dec_word(dec_word), .dec_reg_dest(dec_reg_dest),
    .dec_count_reg(dec_count_reg), .dec_mod(dec_mod), .dec_reg(dec_reg), .dec_rm(dec_rm),
    .dec_imm_bytes(dec_imm_bytes), .dec_flags_only(dec_flags_only),
    .dec_repeat(dec_repeat), .dec_repeat_z(dec_repeat_z), .dec_illegal(dec_illegal));
  asjd_queue_eu_model i_asjd_queue_eu_model (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .q_ready(q_ready), .dec_valid(dec_valid),
    .stall_cycles(stall_cycles), .q_byte(q_byte), .q_valid(q_valid), .dec_ready(dec_ready));

  // Free-running 25 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Compares one value and counts the result.
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Sends n bytes, waits for the issue handshake, checks x = {illegal, word, imm}.
  task automatic row(input logic [7:0] b0, input logic [7:0] b1, input int n,
                     input asjd_op_t op, input asjd_form_t fm, input logic [3:0] x);
    int k;
    if (n > 0)
      i_asjd_queue_eu_model.push(b0);
    if (n > 1)
      i_asjd_queue_eu_model.push(b1);
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (!(dec_valid === 1'b1 && dec_ready === 1'b1) && k < 40);
    chk("op", 8'(dec_op), 8'(op));
    chk("illegal", 8'(dec_illegal), 8'(x[3]));
    if (fm != F_NO)
      chk("form", 8'(dec_form), 8'(fm));
    if (op != ASJD_OP_NONE)
    begin
      chk("word", 8'(dec_word), 8'(x[2]));
      chk("imm", 8'(dec_imm_bytes), 8'(x[1:0]));
    end
  endtask

  // Add-with-carry, subtract and borrow forms with size and direction bits.
  task automatic t_arith;
    row(8'h10, 8'hc8, 2, ASJD_OP_ADC, F_RR, 4'h0);
    chk("dest", 8'(dec_reg_dest), 8'h00);
    row(8'h13, 8'hde, 2, ASJD_OP_ADC, F_RR, 4'h4);
    chk("dest", 8'(dec_reg_dest), 8'h01);
    chk("fields", {dec_mod, dec_reg, dec_rm}, 8'hde);
    row(8'h80, 8'hd1, 2, ASJD_OP_ADC, F_RI, 4'h1);
    row(8'h81, 8'hd1, 2, ASJD_OP_ADC, F_RI, 4'h6);
    row(8'h83, 8'hd1, 2, ASJD_OP_ADC, F_RI, 4'h5);
    row(8'h15, 8'h00, 1, ASJD_OP_ADC, F_AI, 4'h6);
    row(8'h2a, 8'hc0, 2, ASJD_OP_SUB, F_RR, 4'h0);
    row(8'h81, 8'he8, 2, ASJD_OP_SUB, F_RI, 4'h6);
    row(8'h2c, 8'h00, 1, ASJD_OP_SUB, F_AI, 4'h1);
    row(8'h19, 8'hc0, 2, ASJD_OP_SWB, F_RR, 4'h4);
    row(8'h82, 8'hd8, 2, ASJD_OP_SWB, F_RI, 4'h1);
    row(8'h1d, 8'h00, 1, ASJD_OP_SWB, F_AI, 4'h6);
  endtask

  // AND with immediates and the flag-only test on the accumulator.
  task automatic t_logic;
    row(8'h80, 8'he0, 2, ASJD_OP_AND, F_RI, 4'h1);
    row(8'h81, 8'he7, 2, ASJD_OP_AND, F_RI, 4'h6);
    row(8'h25, 8'h00, 1, ASJD_OP_AND, F_AI, 4'h6);
    chk("flags", 8'(dec_flags_only), 8'h00);
    row(8'ha8, 8'h00, 1, ASJD_OP_TEST, F_AI, 4'h1);
    chk("flags", 8'(dec_flags_only), 8'h01);
  endtask

  // Every selector of the unary group and of the shift group, with the size bit alternating between selectors.
  task automatic t_groups;
    asjd_op_t un [8] = '{ASJD_OP_TEST, ASJD_OP_NONE, ASJD_OP_NOT, ASJD_OP_CHS,
                         ASJD_OP_MLU, ASJD_OP_MULS, ASJD_OP_DIV, ASJD_OP_DIVS};
    asjd_op_t sh [8] = '{ASJD_OP_ROTL, ASJD_OP_ROTR, ASJD_OP_RLC_C, ASJD_OP_RRC_C,
                         ASJD_OP_SHLEFT, ASJD_OP_SHRL, ASJD_OP_NONE, ASJD_OP_SHRA};
    logic [7:0] b1;
    for (int i = 0; i < 8; i++)
    begin
      b1 = {2'b11, 3'(i), 3'h2};
      row(8'hf6 | 8'(i % 2), b1, 2, un[i], F_NO, {i == 1, 1'(i % 2), 2'(i == 0)});
      chk("flags", 8'(dec_flags_only), 8'(i == 0));
      row(8'hd0 | 8'(i % 4), b1, 2, sh[i], F_NO, {i == 6, 1'(i % 2), 2'h0});
      if (i != 6)
        chk("count", 8'(dec_count_reg), 8'((i / 2) % 2));
    end
  endtask

  // Adjust and extend opcodes, with a bad base byte after the multiply adjust.
  task automatic t_adjust;
    row(8'h37, 8'h00, 1, ASJD_OP_AAJ, F_NO, 4'h0);
    row(8'h27, 8'h00, 1, ASJD_OP_DAJ, F_NO, 4'h0);
    row(8'h3f, 8'h00, 1, ASJD_OP_ASJ, F_NO, 4'h0);
    row(8'h2f, 8'h00, 1, ASJD_OP_DSJ, F_NO, 4'h0);
    row(8'hd4, 8'h0a, 2, ASJD_OP_AMJ, F_NO, 4'h0);
    row(8'hd4, 8'h0b, 2, ASJD_OP_NONE, F_NO, 4'h8);
    row(8'hd5, 8'h0a, 2, ASJD_OP_ADJ, F_NO, 4'h0);
    row(8'h98, 8'h00, 1, ASJD_OP_XBW_EXT, F_NO, 4'h4);
    row(8'h99, 8'h00, 1, ASJD_OP_XWD_EXT, F_NO, 4'h4);
  endtask

  // String operations against a slow execution unit, then the repeat prefix.
  task automatic t_string;
    stall_cycles = 4'h3;
    row(8'ha4, 8'h00, 1, ASJD_OP_SMOVE, F_NO, 4'h0);
    row(8'ha7, 8'h00, 1, ASJD_OP_SCMP, F_NO, 4'h4);
    row(8'hae, 8'h00, 1, ASJD_OP_SSCAN, F_NO, 4'h0);
    row(8'had, 8'h00, 1, ASJD_OP_SLOAD, F_NO, 4'h4);
    row(8'haa, 8'h00, 1, ASJD_OP_SSTORE, F_NO, 4'h0);
    chk("rep", 8'(dec_repeat), 8'h00);
    row(8'hf3, 8'ha5, 2, ASJD_OP_SMOVE, F_NO, 4'h4);
    chk("rep", 8'({dec_repeat, dec_repeat_z}), 8'h03);
    row(8'hf2, 8'haf, 2, ASJD_OP_SSCAN, F_NO, 4'h4);
    chk("rep", 8'({dec_repeat, dec_repeat_z}), 8'h02);
    row(8'ha4, 8'h00, 1, ASJD_OP_SMOVE, F_NO, 4'h0);
    chk("rep", 8'(dec_repeat), 8'h00);
    row(8'hf4, 8'h00, 1, ASJD_OP_NONE, F_NO, 4'h8);
    stall_cycles = 4'h0;
  endtask

  // Jump forms and a neighbouring call selector that must not decode as a jump.
  task automatic t_jump;
    row(8'he9, 8'h00, 1, ASJD_OP_JUMP, F_NO, 4'h6);
    row(8'heb, 8'h00, 1, ASJD_OP_JUMP, F_NO, 4'h5);
    row(8'hff, 8'he3, 2, ASJD_OP_JUMP, F_NO, 4'h4);
    row(8'hff, 8'hd3, 2, ASJD_OP_NONE, F_NO, 4'h0);
  endtask

  // Reset for 20 cycles, run every scenario, then report.
  initial
  begin
    sys_rst = 1'b1;
    stall_cycles = 4'h0;
    repeat (20) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    t_arith();
    t_logic();
    t_groups();
    t_adjust();
    t_string();
    t_jump();
    end_sim();
  end

  // Cuts a hung run short after far more cycles than the scenarios need.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      end_sim();
    end
  end
endmodule

// File: sim/asjd_queue_eu_model.sv
// Behavioural prefetch queue and execution unit facing the decoder.
`timescale 1ns/1ps
module asjd_queue_eu_model
(
  input  logic       ref_clk,
  input  logic       sys_rst,
  input  logic       q_ready,
  input  logic       dec_valid,
  input  logic [3:0] stall_cycles,
  output logic [7:0] q_byte,
  output logic       q_valid,
  output logic       dec_ready
);
  logic [7:0] fifo [$];
  logic [3:0] wait_r;
  logic       took;
  logic       done;

  // Queues one byte for delivery.
  task automatic push(input logic [7:0] b);
    fifo.push_back(b);
  endtask

  // Offers bytes and accepts work just after each edge; an idle byte line toggles.
  initial
  begin
    q_byte = 8'h00;
    q_valid = 1'b0;
    dec_ready = 1'b0;
    wait_r = 4'h0;
    forever
    begin
      @(posedge ref_clk);
      took = q_valid && q_ready;
      done = dec_valid && dec_ready;
      #1;
      if (took)
        void'(fifo.pop_front());
      q_valid = !sys_rst && fifo.size() > 0;
      q_byte = q_valid ? fifo[0] : ~q_byte;
      if (done || sys_rst)
      begin
        dec_ready = 1'b0;
        wait_r = stall_cycles;
      end
      else if (dec_valid && wait_r == 4'h0)
        dec_ready = 1'b1;
      else if (dec_valid)
        wait_r = wait_r - 4'h1;
    end
  end
endmodule
